// ### hdl/rcc_pkg.sv
// Constants, types and register map of the channel, assessment and strength control block.
// Assumes a single 200 MHz clock and a one-cycle-latency register port.
package rcc_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [9:0] OFF_BEACON_TX_CONTROL_ONE = 10'h025;
  localparam logic [9:0] OFF_RF_MODE_CONTROL = 10'h036;
  localparam logic [9:0] OFF_ASSESSMENT_CONFIG = 10'h03a;
  localparam logic [9:0] OFF_STRENGTH_MEASURE_CONTROL = 10'h03e;
  localparam logic [9:0] OFF_ENERGY_THRESHOLD = 10'h03f;
  localparam logic [9:0] OFF_RF_FREQUENCY_CONFIG = 10'h200;
  localparam logic [9:0] OFF_SIGNAL_STRENGTH_RESULT = 10'h210;
  // ==========================================================
  // Field positions
  localparam int CHANNEL_LSB = 4;
  localparam int RF_FSM_RESET_BIT = 2;
  localparam int MODE_LSB = 6;
  localparam int CS_THRESHOLD_LSB = 2;
  localparam int AVG_COUNT_LSB = 4;
  localparam int REQUEST_BIT = 7;
  localparam int APPEND_BIT = 6;
  localparam int READY_BIT = 0;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_BEACON_TX_CONTROL_ONE = 8'h00;
  localparam logic [7:0] RST_RF_MODE_CONTROL = 8'h00;
  localparam logic [7:0] RST_ASSESSMENT_CONFIG = 8'h00;
  localparam logic [7:0] RST_STRENGTH_MEASURE_CONTROL = 8'h00;
  localparam logic [7:0] RST_ENERGY_THRESHOLD = 8'h00;
  localparam logic [7:0] RST_RF_FREQUENCY_CONFIG = 8'h03;
  localparam logic [7:0] RST_SIGNAL_STRENGTH_RESULT = 8'h00;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int SYMBOL_NS = 16000;
  localparam int SYMBOL_CYCLES = SYMBOL_NS * CLK_MHZ / 1000;
  localparam int MEASURE_SYMBOLS = 8;
  localparam int CALIBRATE_US = 192;
  localparam int CALIBRATE_CYCLES = CALIBRATE_US * CLK_MHZ;
  // ==========================================================
  // Types
  typedef enum logic [1:0]
  {
    MODE_NONE = 2'b00,
    MODE_CARRIER = 2'b01,
    MODE_ENERGY = 2'b10,
    MODE_BOTH = 2'b11
  } rcc_mode_e;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_MEASURE = 2'b01,
    ST_CALIB = 2'b10
  } rcc_state_e;

  typedef struct packed
  {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rcc_bus_s;

  typedef struct packed
  {
    logic carrier;
    logic [3:0] corr;
    logic [7:0] energy;
  } rcc_radio_s;
endpackage

// ### hdl/rcc_top.sv
// Register bank and control logic for channel, clear channel assessment and strength.
// Assumes a host on the plain register port and radio front-end inputs on SYS_CLK.
// Radio and packet inputs come from logic on the same clock, so none is synchronised.
// The averaging count field is kept for software; the measurement is fixed at 8 symbols.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module rcc_top
  import rcc_pkg::*;
#(
  parameter int CAL_CYCLES = CALIBRATE_CYCLES,
  parameter int SYM_CYCLES = SYMBOL_CYCLES
)
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // Register port
  input wire logic [9:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // Radio front end, same clock
  input wire logic RADIO_CARRIER,
  input wire logic [3:0] RADIO_CORR,
  input wire logic [7:0] RADIO_ENERGY,
  // Packet receive events
  input wire logic PKT_END,
  input wire logic PKT_GOOD,
  // Channel and calibration
  output logic [3:0] CHANNEL,
  output logic RF_FSM_RESET,
  output logic CALIBRATING,
  // Assessment and appended strength
  output logic MEDIUM_BUSY,
  output logic APPEND_VALID,
  output logic [7:0] APPEND_BYTE
);
  // Bundled inputs
  rcc_bus_s bus;
  rcc_radio_s radio;
  // Register storage
  logic [7:0] beacon_tx_control_one;
  logic [7:0] rf_mode_control;
  logic [7:0] assessment_config;
  logic [7:0] strength_measure_control;
  logic [7:0] energy_threshold;
  logic [7:0] rf_frequency_config;
  logic [7:0] signal_strength_result;
  // Sequencer state
  rcc_state_e state;
  rcc_state_e next_state;
  logic [21:0] count;
  logic [21:0] next_count;
  logic [3:0] sym_left;
  logic [3:0] next_sym_left;
  logic [11:0] acc;
  logic [11:0] next_acc;
  // Decode and selection results
  logic [7:0] avg;
  logic [7:0] ready_sample;
  logic [7:0] rd_mux;
  rcc_mode_e mode;
  logic next_busy;
  logic next_append_valid;
  logic [7:0] next_smc;

  // ==========================================================
  // Bus and radio bundles
  assign bus = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};
  assign radio = '{carrier: RADIO_CARRIER, corr: RADIO_CORR, energy: RADIO_ENERGY};

  // Write decode
  // A write to an unmapped offset matches nothing and is dropped
  function automatic logic hit(input rcc_bus_s b, input logic [9:0] off);
    hit = b.wr && (b.addr == off);
  endfunction

  wire wr_btc = hit(bus, OFF_BEACON_TX_CONTROL_ONE);
  wire wr_rfc = hit(bus, OFF_RF_MODE_CONTROL);
  wire wr_asc = hit(bus, OFF_ASSESSMENT_CONFIG);
  wire wr_smc = hit(bus, OFF_STRENGTH_MEASURE_CONTROL);
  wire wr_eth = hit(bus, OFF_ENERGY_THRESHOLD);
  wire wr_rff = hit(bus, OFF_RF_FREQUENCY_CONFIG);
  wire request = wr_smc && bus.wdata[REQUEST_BIT];
  wire [3:0] cs_threshold = assessment_config[CS_THRESHOLD_LSB +: 4];
  wire [1:0] avg_sel = beacon_tx_control_one[AVG_COUNT_LSB +: 2];
  wire energy_above = radio.energy > energy_threshold;
  wire carrier_seen = radio.carrier && (radio.corr >= cs_threshold);
  wire fsm_reset_fall = wr_rfc && rf_mode_control[RF_FSM_RESET_BIT]
    && !bus.wdata[RF_FSM_RESET_BIT];
  // Completion: boundary of the last symbol, one cycle wide
  wire done = (state == ST_MEASURE) && (count == 22'h000000) && (sym_left == 4'h1);

  // ==========================================================
  // Configuration registers; contents survive the RF machine reset
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      beacon_tx_control_one <= RST_BEACON_TX_CONTROL_ONE;
      rf_mode_control <= RST_RF_MODE_CONTROL;
      assessment_config <= RST_ASSESSMENT_CONFIG;
      energy_threshold <= RST_ENERGY_THRESHOLD;
      rf_frequency_config <= RST_RF_FREQUENCY_CONFIG;
    end
    else
    begin
      // Reserved low nibble reads zero
      if (wr_btc)
        beacon_tx_control_one <= {bus.wdata[7:4], 4'h0};
      // Top three bits are reserved
      if (wr_rfc)
        rf_mode_control <= {3'h0, bus.wdata[4:0]};
      // Mode and carrier threshold; two reserved bits
      if (wr_asc)
        assessment_config <= {bus.wdata[7:2], 2'h0};
      // Full byte, same scale as the strength value
      if (wr_eth)
        energy_threshold <= bus.wdata;
      // Option nibble is stored as written; keeping it is up to the host
      if (wr_rff)
        rf_frequency_config <= bus.wdata;
    end
  end

  // ==========================================================
  // Next strength control. Ready set by completion wins over a request
  // clearing it in the same cycle; the append enable of such a write is
  // still taken so that no host setting is lost. Bits 5..1 stay zero.
  always_comb
  begin
    next_smc = strength_measure_control;
    if (done)
    begin
      next_smc[REQUEST_BIT] = 1'b0;
      next_smc[READY_BIT] = 1'b1;
      if (wr_smc)
        next_smc[APPEND_BIT] = bus.wdata[APPEND_BIT];
    end
    else if (wr_smc)
    begin
      next_smc[REQUEST_BIT] = bus.wdata[REQUEST_BIT];
      next_smc[APPEND_BIT] = bus.wdata[APPEND_BIT];
      if (request)
        next_smc[READY_BIT] = 1'b0;
    end
  end

  // Strength control register
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      strength_measure_control <= RST_STRENGTH_MEASURE_CONTROL;
    else
      strength_measure_control <= next_smc;
  end

  // ==========================================================
  // Measurement and calibration sequencer
  // A request in idle starts eight symbol counts from a cleared sum.
  // At each symbol boundary one energy sample is added; the sum of
  // eight bytes needs eleven bits, so the twelve-bit sum never wraps.
  // A falling machine-reset bit forces calibration from any state and
  // drops a measurement in flight; ready then stays clear until the
  // host asks again. Requests made during calibration are ignored,
  // which is why the host must wait out the calibration time.
  // Average comes from the sum including the last sample: floor of sum / 8
  assign avg = next_acc[10:3];
  always_comb
  begin
    next_state = state;
    next_count = count;
    next_sym_left = sym_left;
    next_acc = acc;
    case (state)
      ST_IDLE:
      begin
        if (request)
        begin
          next_state = ST_MEASURE;
          next_count = 22'(SYM_CYCLES - 1);
          next_sym_left = 4'(MEASURE_SYMBOLS);
          next_acc = 12'h000;
        end
      end
      ST_MEASURE:
      begin
        if (count == 22'h000000)
        begin
          next_acc = acc + {4'h0, radio.energy};
          next_count = 22'(SYM_CYCLES - 1);
          next_sym_left = sym_left - 4'h1;
          if (sym_left == 4'h1)
            next_state = ST_IDLE;
        end
        else
          next_count = count - 22'h000001;
      end
      ST_CALIB:
      begin
        if (count == 22'h000000)
          next_state = ST_IDLE;
        else
          next_count = count - 22'h000001;
      end
      default:
        next_state = ST_IDLE;
    endcase
    // A falling machine-reset bit always restarts calibration; a measurement in flight is dropped
    if (fsm_reset_fall)
    begin
      next_state = ST_CALIB;
      next_count = 22'(CAL_CYCLES - 1);
    end
  end

  // Sequencer registers
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      state <= ST_IDLE;
      count <= 22'h000000;
      sym_left <= 4'h0;
      acc <= 12'h000;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      sym_left <= next_sym_left;
      acc <= next_acc;
    end
  end

  // Result register takes the average on completion and holds it
  // until the next completion; an aborted run leaves it as it was
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      signal_strength_result <= RST_SIGNAL_STRENGTH_RESULT;
    else if (done)
      signal_strength_result <= avg;
  end

  // ==========================================================
  // Assessment mode decode from the config register
  assign mode = rcc_mode_e'(assessment_config[MODE_LSB +: 2]);

  // Busy per mode; mode 00 never reports busy. Carrier compare is at or
  // above its threshold, energy strictly above, so energy equal to the
  // threshold reads idle.
  always_comb
  begin
    next_busy = 1'b0;
    case (mode)
      MODE_ENERGY:
        next_busy = energy_above;
      MODE_CARRIER:
        next_busy = carrier_seen;
      MODE_BOTH:
        next_busy = carrier_seen && energy_above;
      default:
        next_busy = 1'b0;
    endcase
  end

  // Strength octet goes last, after check and quality octets; a bad
  // packet gets no octet, as the receive buffer discards it anyway
  assign next_append_valid = PKT_END && PKT_GOOD
    && strength_measure_control[APPEND_BIT];

  // Registered outputs, one cycle after their inputs
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      MEDIUM_BUSY <= 1'b0;
      APPEND_VALID <= 1'b0;
      APPEND_BYTE <= 8'h00;
    end
    else
    begin
      MEDIUM_BUSY <= next_busy;
      APPEND_VALID <= next_append_valid;
      APPEND_BYTE <= radio.energy;
    end
  end

  // Channel and machine reset follow their registers directly, so the
  // radio sees a host write at the very next cycle
  assign CHANNEL = rf_frequency_config[CHANNEL_LSB +: 4];
  assign RF_FSM_RESET = rf_mode_control[RF_FSM_RESET_BIT];
  assign CALIBRATING = (state == ST_CALIB);
  assign ready_sample = strength_measure_control;

  // ==========================================================
  // Read port, data one cycle after the strobe; unmapped reads zero
  // One offset per branch; holes in the map fall through to zero
  always_comb
  begin
    rd_mux = 8'h00;
    if (bus.addr == OFF_BEACON_TX_CONTROL_ONE)
      rd_mux = beacon_tx_control_one;
    else if (bus.addr == OFF_RF_MODE_CONTROL)
      rd_mux = rf_mode_control;
    else if (bus.addr == OFF_ASSESSMENT_CONFIG)
      rd_mux = assessment_config;
    else if (bus.addr == OFF_STRENGTH_MEASURE_CONTROL)
      rd_mux = ready_sample;
    else if (bus.addr == OFF_ENERGY_THRESHOLD)
      rd_mux = energy_threshold;
    else if (bus.addr == OFF_RF_FREQUENCY_CONFIG)
      rd_mux = rf_frequency_config;
    else if (bus.addr == OFF_SIGNAL_STRENGTH_RESULT)
      rd_mux = signal_strength_result;
    else
      rd_mux = 8'h00;
  end

  // Read data register; zero outside the cycle after a read strobe
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      REG_RDATA <= 8'h00;
    else if (bus.rd)
      REG_RDATA <= rd_mux;
    else
      REG_RDATA <= 8'h00;
  end
endmodule
`default_nettype wire

// ### verif/rcc_asserts.sv
// Checker for the channel, assessment and strength control block.
// Sees only the ports of rcc_top; shadows host writes it needs.
`timescale 1ns/100ps
`default_nettype none
module rcc_asserts
(
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic [9:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic RADIO_CARRIER,
  input wire logic [3:0] RADIO_CORR,
  input wire logic [7:0] RADIO_ENERGY,
  input wire logic PKT_END,
  input wire logic PKT_GOOD,
  input wire logic [3:0] CHANNEL,
  input wire logic RF_FSM_RESET,
  input wire logic MEDIUM_BUSY,
  input wire logic APPEND_VALID,
  input wire logic [7:0] APPEND_BYTE
);
  logic [7:0] cfg;
  logic [7:0] edt;
  logic app;
  wire logic cs_hit = RADIO_CARRIER && (RADIO_CORR >= cfg[5:2]);
  wire logic en_hi = RADIO_ENERGY > edt;
  wire logic pkt = PKT_END && PKT_GOOD && app;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  // ==========
  // Shadow of settings; sampled before update, like the design's own
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      cfg <= 8'h00;
      edt <= 8'h00;
      app <= 1'b0;
    end
    else if (REG_WR)
    begin
      if (REG_ADDR == 10'h03a) cfg <= REG_WDATA;
      if (REG_ADDR == 10'h03f) edt <= REG_WDATA;
      if (REG_ADDR == 10'h03e) app <= REG_WDATA[6];
    end
  end
  // ==========
  // Properties
  AST_CHAN: assert property (REG_WR && REG_ADDR == 10'h200 |=> CHANNEL == $past(REG_WDATA[7:4]))
    else $error("channel not taken from write");
  AST_RF_RESET: assert property (REG_WR && REG_ADDR == 10'h036 |=> RF_FSM_RESET == $past(REG_WDATA[2]))
    else $error("machine reset bit mismatch");
  AST_ED: assert property (cfg[7:6] == 2'b10 |=> MEDIUM_BUSY == $past(en_hi))
    else $error("energy mode busy wrong");
  AST_CS: assert property (cfg[7:6] == 2'b01 |=> MEDIUM_BUSY == $past(cs_hit))
    else $error("carrier mode busy wrong");
  AST_BOTH: assert property (cfg[7:6] == 2'b11 |=> MEDIUM_BUSY == $past(cs_hit && en_hi))
    else $error("combined mode busy wrong");
  AST_APPEND: assert property (pkt |=> APPEND_VALID && APPEND_BYTE == $past(RADIO_ENERGY))
    else $error("strength byte not appended");
  AST_NO_APPEND: assert property (!pkt |=> !APPEND_VALID)
    else $error("spurious append");
  AST_READY_CLR: assert property (REG_WR && REG_ADDR == 10'h03e && REG_WDATA[7]
    ##1 REG_RD && REG_ADDR == 10'h03e |=> !REG_RDATA[0])
    else $error("ready not cleared by request");
endmodule
bind rcc_top rcc_asserts rcc_asserts_i (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .RADIO_CARRIER(RADIO_CARRIER), .RADIO_CORR(RADIO_CORR),
  .RADIO_ENERGY(RADIO_ENERGY), .PKT_END(PKT_END), .PKT_GOOD(PKT_GOOD),
  .CHANNEL(CHANNEL), .RF_FSM_RESET(RF_FSM_RESET), .MEDIUM_BUSY(MEDIUM_BUSY),
  .APPEND_VALID(APPEND_VALID), .APPEND_BYTE(APPEND_BYTE));
`default_nettype wire

// ### verif/rcc_host.sv
// Host model: register port master for the control block.
// Assumes tasks are entered just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module rcc_host
(
  input wire logic clk,
  output logic [9:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  // ==========
  // Idle bus at time zero
  initial
  begin
    addr = 10'h000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // Write leaves its strobe up so a read may follow with no gap
  task automatic put(input logic [9:0] a, input logic [7:0] d);
    wr <= 1'b1;
    rd <= 1'b0;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask
  // Data stand only in the cycle after the read edge
  task automatic get(input logic [9:0] a, output logic [7:0] d);
    rd <= 1'b1;
    wr <= 1'b0;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask
  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### verif/test_rcc_top.sv
// Self-checking bench for rcc_top with a host model on its register port.
// Assumes shortened counts: 20 calibration cycles, 4-cycle symbols.
`timescale 1ns/100ps
`default_nettype none
module test_rcc_top;
  logic clk, rst, car, pend, pgood, busy, av, frst, cal, wr, rd;
  logic [3:0] corr, chan;
  logic [7:0] en, rdata, d, e, th, cfg, ab, wdata;
  logic [9:0] addr;
  logic [31:0] seed = 32'h1e15;
  logic [31:0] r;
  logic x;
  int fails = 0;
  int num_checks = 0;
  logic [9:0] ra [6] = '{10'h025, 10'h03a, 10'h03f, 10'h210, 10'h100, 10'h200};
  logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
  logic [7:0] wv [6] = '{8'hf0, 8'hfc, 8'hff, 8'h00, 8'h00, 8'hf3};
  rcc_top #(.CAL_CYCLES(20), .SYM_CYCLES(4)) rcc_top_i (.SYS_CLK(clk), .SYS_RST(rst),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .RADIO_CARRIER(car), .RADIO_CORR(corr), .RADIO_ENERGY(en), .PKT_END(pend),
    .PKT_GOOD(pgood), .CHANNEL(chan), .RF_FSM_RESET(frst), .CALIBRATING(cal),
    .MEDIUM_BUSY(busy), .APPEND_VALID(av), .APPEND_BYTE(ab));
  rcc_host rcc_host_i (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));
  // ==========
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Threshold compares: carrier at or above, energy strictly above
  function automatic logic exp_busy(logic [7:0] c, logic [7:0] t, logic k,
    logic [3:0] q, logic [7:0] g);
    logic s;
    logic h;
    s = k && q >= c[5:2];
    h = g > t;
    return (c[7:6] == 2'b01 && s) || (c[7:6] == 2'b10 && h) || (c[7:6] == 2'b11 && s && h);
  endfunction
  task automatic chk(input string n, input logic [7:0] xp, input logic [7:0] g);
    num_checks++;
    if (g !== xp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", n, xp, g);
      fails++;
    end
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Watchdog at 20000 cycles, far above the expected run of under a thousand cycles
  initial
  begin
    #100000;
    fails++;
    tally_and_finish();
  end
  // ==========
  // Main sequence
  initial
  begin
    {rst, car, pend, pgood, corr, en} = {1'b1, 15'h0};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset values, access kinds, read-only and unmapped places
    for (int i = 0; i < 6; i++)
    begin
      rcc_host_i.get(ra[i], d);
      chk("reset value", rv[i], d);
      rcc_host_i.put(ra[i], ra[i] == 10'h200 ? 8'hf3 : 8'hff);
      rcc_host_i.get(ra[i], d);
      chk("access", wv[i], d);
    end
    // Every channel, each followed by machine reset and calibration
    for (int c = 0; c < 16; c++)
    begin
      rcc_host_i.put(10'h200, {c[3:0], 4'h3});
      rcc_host_i.put(10'h036, 8'h04);
      rcc_host_i.put(10'h036, 8'h00);
      rcc_host_i.idle(2);
      @(negedge clk);
      chk("calibrating", 8'h01, {7'h0, cal});
      rcc_host_i.idle(22);
      rcc_host_i.get(10'h200, d);
      chk("freq config", {c[3:0], 4'h3}, d);
      chk("channel", {c[3:0], 4'h0}, {chan, cal, frst, 2'b00});
    end
    // All assessment modes, random inputs, energy equal to threshold among them
    for (int m = 0; m < 4; m++)
    begin
      r = rnd();
      cfg = {m[1:0], r[3:0], 2'b00};
      th = r[15:8];
      rcc_host_i.put(10'h03a, cfg);
      rcc_host_i.put(10'h03f, th);
      rcc_host_i.idle(1);
      for (int k = 0; k < 30; k++)
      begin
        x = exp_busy(cfg, th, car, corr, en);
        r = rnd();
        car <= r[0];
        corr <= r[7:4];
        en <= r[1] ? th : r[15:8];
        @(negedge clk);
        chk("busy", {7'h0, x}, {7'h0, busy});
        @(posedge clk);
      end
    end
    // On-demand measurement twice, so the second request meets a set ready flag
    for (int m = 0; m < 2; m++)
    begin
      e = 8'(rnd());
      en <= e;
      rcc_host_i.idle(1);
      rcc_host_i.put(10'h03e, 8'hc0);
      rcc_host_i.get(10'h03e, d);
      chk("request", 8'hc0, d);
      for (int t = 0; t < 40 && d[0] !== 1'b1; t++) rcc_host_i.get(10'h03e, d);
      chk("ready", 8'h41, d);
      rcc_host_i.get(10'h210, d);
      chk("strength", e, d);
    end
    // Packet end, bad then good, with append enabled
    for (int k = 0; k < 2; k++)
    begin
      e = 8'(rnd());
      pend <= 1'b1;
      pgood <= k[0];
      en <= e;
      @(posedge clk);
      pend <= 1'b0;
      @(negedge clk);
      chk("append valid", {7'h0, k[0]}, {7'h0, av});
      chk("append byte", e, ab);
      @(posedge clk);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
